// ---- hdl/field_rev_map.vh ----
// Register map, field positions, reset values and timing constants of the field reversal sequencer
`ifndef FIELD_REV_MAP_VH
`define FIELD_REV_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define A_CTRL 8'h00
`define A_THRESH 8'h04
`define A_RESTART_DLY 8'h08
`define A_SAVE_LVL 8'h0c
`define A_SAVE_DLY 8'h10
`define A_OUTSEL 8'h14
`define A_FIELD_NOM 8'h18
`define A_RAMP_STEP 8'h1c
`define A_STATUS 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_EN 0
`define CTRL_PER 2:1
`define CTRL_SRC 3
`define OUT_POS 2:0
`define OUT_NEG 6:4
`define OUT_AUX 9:8
`define DLY_W 14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL 4'h0
`define RST_THRESH 16'h0400
`define RST_RESTART_DLY 14'h0014
`define RST_SAVE_LVL 16'h0800
`define RST_SAVE_DLY 14'h0064
`define RST_OUTSEL 10'h010
`define RST_FIELD_NOM 16'h4000
`define RST_RAMP_STEP 16'h0010

// ----------------------------------------------------------------
// Encodings and timing
// ----------------------------------------------------------------
`define PER_10MS 2'h0
`define PER_5MS 2'h1
`define LIMIT_ANGLE_DEG 8'ha5
`define CLK_PERIOD_NS 100
`define CYCLE_10MS_NS 10000000
`define CYCLE_5MS_NS 5000000
`define CYCLE_3MS3_NS 3300000
`define HTRANS_NONSEQ_BIT 1

`endif

// ---- hdl/cycle_tick.v ----
// Software cycle divider: one-cycle enable at the selected cycle period
`timescale 1ns/1ns
`include "field_rev_map.vh"
module cycle_tick #(
  parameter integer CLKS_10MS = 100000,
  parameter integer CLKS_5MS = 50000,
  parameter integer CLKS_3MS3 = 33000
) (
  input wire hclk, // Bus clock
  input wire hresetn, // Async reset, active low
  input wire [1:0] period_sel, // Cycle period code
  output reg tick // One-cycle pulse per software cycle
);
  reg [16:0] cnt_reg;
  reg [16:0] last;

  always @* begin
    case (period_sel)
      `PER_10MS: last = CLKS_10MS[16:0] - 17'h00001;
      `PER_5MS: last = CLKS_5MS[16:0] - 17'h00001;
      default: last = CLKS_3MS3[16:0] - 17'h00001;
    endcase
  end

  // Compare with >= so that a shorter period taking effect mid-count cannot overrun
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 17'h00000;
      tick <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 17'h00000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 17'h00001;
      tick <= 1'b0;
    end
  end
endmodule // cycle_tick

// ---- hdl/cycle_delay.v ----
// Delay counted in software cycles, restarted by a start pulse
`timescale 1ns/1ns
`include "field_rev_map.vh"
module cycle_delay (
  input wire hclk, // Bus clock
  input wire hresetn, // Async reset, active low
  input wire start, // Load count and begin
  input wire tick, // Software cycle enable
  input wire [`DLY_W-1:0] count, // Cycles to wait
  output reg done // High once the count has elapsed
);
  reg [`DLY_W-1:0] cnt_reg;
  reg busy_reg;

  // A count of zero behaves as one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= {`DLY_W{1'b0}};
      busy_reg <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      cnt_reg <= count;
      busy_reg <= 1'b1;
      done <= 1'b0;
    end else if (tick && busy_reg) begin
      if (cnt_reg <= {{(`DLY_W-1){1'b0}}, 1'b1}) begin
        busy_reg <= 1'b0;
        done <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - {{(`DLY_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // cycle_delay

// ---- hdl/field_reversal_sequencer.v ----
// Field reversal sequencer with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "field_rev_map.vh"
module field_reversal_sequencer #(
  parameter integer CLKS_10MS = `CYCLE_10MS_NS / `CLK_PERIOD_NS,
  parameter integer CLKS_5MS = `CYCLE_5MS_NS / `CLK_PERIOD_NS,
  parameter integer CLKS_3MS3 = `CYCLE_3MS3_NS / `CLK_PERIOD_NS
) (
  input wire hclk, // Clock, 10 MHz
  input wire hresetn, // Async reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready
  output reg hreadyout, // Slave ready
  output reg hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire [15:0] speed_loop_current_demand, // Speed regulator output, signed
  input wire [15:0] alt_current_demand, // Other demand source, signed
  input wire [15:0] field_current_meas, // Measured field current, signed
  input wire [15:0] measured_speed, // Speed feedback, signed
  input wire [15:0] ramp_input_reference, // Reference ahead of the ramp, signed
  input wire ramp_enable, // Ramp function on
  input wire regulating, // Converter in regulation state
  input wire motor_stopped, // Motor at standstill
  input wire loss_of_field_fault, // Loss-of-field protection active
  input wire av_sensor_fault, // Armature voltage sensor fault active
  output reg [15:0] field_current_reference, // Field reference to exciter, signed
  output reg firing_limit_hold, // Armature firing held at limit
  output reg [7:0] firing_angle_limit, // Limit angle in degrees while held
  output reg current_loop_enable, // Armature current loop enabled
  output reg speed_integrator_clear, // One-cycle clear of speed integrator
  output reg [15:0] working_speed_reference, // Working speed reference, signed
  output reg drive_wait, // Speed loop held waiting for field
  output reg [5:0] logic_out, // Six logic outputs
  output reg tacho_reversal_inhibit, // Reversed-tachometer protection off
  output reg [15:0] aux_variable // Selected auxiliary variable
);
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_REV = 2'h2;
  localparam [1:0] ST_DLY = 2'h3;

  // ----------------------------------------------------------------
  // Host settings and their per-cycle working copies
  // ----------------------------------------------------------------
  reg [3:0] ctrl_reg;
  reg [15:0] thresh_reg;
  reg [`DLY_W-1:0] rdly_reg;
  reg [15:0] slvl_reg;
  reg [`DLY_W-1:0] sdly_reg;
  reg [9:0] outsel_reg;
  reg [15:0] fnom_reg;
  reg [15:0] rstep_reg;
  reg [3:0] ctrl_a;
  reg [15:0] thresh_a;
  reg [`DLY_W-1:0] rdly_a;
  reg [15:0] slvl_a;
  reg [`DLY_W-1:0] sdly_a;
  reg [9:0] outsel_a;
  reg [15:0] fnom_a;
  reg [15:0] rstep_a;

  reg [1:0] state_reg;
  reg field_neg_reg;
  reg regulating_d;
  reg wr_pend;
  reg [7:0] wr_addr;
  wire tick;
  wire restart_done;
  wire save_done;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  wire addr_phase = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  reg [31:0] rd_mux;
  reg saving_active;
  reg pos_ind;
  reg neg_ind;

  always @* begin
    case (haddr[7:0])
      `A_CTRL: rd_mux = {28'h0000000, ctrl_reg};
      `A_THRESH: rd_mux = {16'h0000, thresh_reg};
      `A_RESTART_DLY: rd_mux = {18'h00000, rdly_reg};
      `A_SAVE_LVL: rd_mux = {16'h0000, slvl_reg};
      `A_SAVE_DLY: rd_mux = {18'h00000, sdly_reg};
      `A_OUTSEL: rd_mux = {22'h000000, outsel_reg};
      `A_FIELD_NOM: rd_mux = {16'h0000, fnom_reg};
      `A_RAMP_STEP: rd_mux = {16'h0000, rstep_reg};
      `A_STATUS: rd_mux = {26'h0000000, saving_active, neg_ind, pos_ind, field_neg_reg, state_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctrl_reg <= `RST_CTRL;
      thresh_reg <= `RST_THRESH;
      rdly_reg <= `RST_RESTART_DLY;
      slvl_reg <= `RST_SAVE_LVL;
      sdly_reg <= `RST_SAVE_DLY;
      outsel_reg <= `RST_OUTSEL;
      fnom_reg <= `RST_FIELD_NOM;
      rstep_reg <= `RST_RAMP_STEP;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend) begin
        case (wr_addr)
          `A_CTRL: ctrl_reg <= hwdata[3:0];
          `A_THRESH: thresh_reg <= hwdata[15:0];
          `A_RESTART_DLY: rdly_reg <= hwdata[`DLY_W-1:0];
          `A_SAVE_LVL: slvl_reg <= hwdata[15:0];
          `A_SAVE_DLY: sdly_reg <= hwdata[`DLY_W-1:0];
          `A_OUTSEL: outsel_reg <= hwdata[9:0];
          `A_FIELD_NOM: fnom_reg <= hwdata[15:0];
          `A_RAMP_STEP: rstep_reg <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Settings change only at a cycle boundary so one cycle never mixes old and new values
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a <= `RST_CTRL;
      thresh_a <= `RST_THRESH;
      rdly_a <= `RST_RESTART_DLY;
      slvl_a <= `RST_SAVE_LVL;
      sdly_a <= `RST_SAVE_DLY;
      outsel_a <= `RST_OUTSEL;
      fnom_a <= `RST_FIELD_NOM;
      rstep_a <= `RST_RAMP_STEP;
    end else if (tick) begin
      ctrl_a <= ctrl_reg;
      thresh_a <= thresh_reg;
      rdly_a <= rdly_reg;
      slvl_a <= slvl_reg;
      sdly_a <= sdly_reg;
      outsel_a <= outsel_reg;
      fnom_a <= fnom_reg;
      rstep_a <= rstep_reg;
    end
  end

  // ----------------------------------------------------------------
  // Software cycle and delays
  // ----------------------------------------------------------------
  cycle_tick #(
    .CLKS_10MS(CLKS_10MS),
    .CLKS_5MS(CLKS_5MS),
    .CLKS_3MS3(CLKS_3MS3)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .period_sel(ctrl_a[`CTRL_PER]),
    .tick(tick)
  );

  reg restart_start;
  cycle_delay u_restart (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(restart_start),
    .tick(tick),
    .count(rdly_a),
    .done(restart_done)
  );

  wire leave_reg = regulating_d && !regulating;
  cycle_delay u_save (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(leave_reg),
    .tick(tick),
    .count(sdly_a),
    .done(save_done)
  );

  // ----------------------------------------------------------------
  // Reversal detection and completion
  // ----------------------------------------------------------------
  wire rev_en = ctrl_a[`CTRL_EN];
  wire [15:0] demand = ctrl_a[`CTRL_SRC] ? alt_current_demand : speed_loop_current_demand;
  wire [15:0] demand_mag = demand[15] ? (~demand + 16'h0001) : demand;
  wire req_flip = rev_en && regulating && (demand[15] != field_neg_reg) &&
    (demand_mag > thresh_a);

  wire [15:0] field_mag = saving_active ? slvl_a : fnom_a;
  wire [15:0] field_ref = field_neg_reg ? (~field_mag + 16'h0001) : field_mag;
  wire [16:0] field_err = {field_ref[15], field_ref} - {field_current_meas[15], field_current_meas};
  wire [16:0] field_err_mag = field_err[16] ? (~field_err + 17'h00001) : field_err;
  wire sign_ok = field_current_meas[15] == field_neg_reg;
  wire faults_clear = !loss_of_field_fault && !av_sensor_fault;
  wire err_ok = field_err_mag < {2'h0, field_mag[15:1]};
  wire complete = sign_ok && faults_clear && err_ok;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg restart_load;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_OFF;
      field_neg_reg <= 1'b0;
      restart_start <= 1'b0;
      restart_load <= 1'b0;
      regulating_d <= 1'b0;
    end else begin
      regulating_d <= regulating;
      restart_start <= 1'b0;
      restart_load <= 1'b0;
      if (!rev_en) begin
        field_neg_reg <= 1'b0;
      end
      if (!regulating) begin
        state_reg <= ST_OFF;
      end else if (tick) begin
        case (state_reg)
          ST_OFF, ST_RUN: begin
            if (req_flip) begin
              field_neg_reg <= ~field_neg_reg;
              state_reg <= ST_REV;
            end else begin
              state_reg <= ST_RUN;
            end
          end
          ST_REV: begin
            if (req_flip) begin
              field_neg_reg <= ~field_neg_reg;
            end else if (complete) begin
              state_reg <= ST_DLY;
              restart_start <= 1'b1;
            end
          end
          ST_DLY: begin
            if (req_flip) begin
              field_neg_reg <= ~field_neg_reg;
              state_reg <= ST_REV;
            end else if (restart_done) begin
              state_reg <= ST_RUN;
              restart_load <= 1'b1;
            end
          end
          default: state_reg <= ST_OFF;
        endcase
      end else if ((state_reg == ST_DLY) && restart_done && !restart_start) begin
        state_reg <= ST_RUN;
        restart_load <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  wire reversing = (state_reg == ST_REV) || (state_reg == ST_DLY);

  always @* begin
    saving_active = !regulating && save_done && motor_stopped;
    pos_ind = 1'b0;
    neg_ind = 1'b0;
    if (state_reg == ST_OFF) begin
      pos_ind = 1'b0;
    end else if (reversing) begin
      pos_ind = 1'b1;
      neg_ind = 1'b1;
    end else begin
      pos_ind = field_neg_reg;
      neg_ind = !field_neg_reg;
    end
  end

  wire [5:0] logic_next;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_out
      localparam [2:0] IDX = g;
      assign logic_next[g] = ((outsel_a[`OUT_POS] == IDX) && pos_ind) ||
        ((outsel_a[`OUT_NEG] == IDX) && neg_ind);
    end
  endgenerate

  // Ramp toward the input; stepping saturates at the target so it never overshoots
  wire [16:0] ramp_gap = {ramp_input_reference[15], ramp_input_reference} -
    {working_speed_reference[15], working_speed_reference};
  wire ramp_up = !ramp_gap[16];
  wire [16:0] gap_mag = ramp_up ? ramp_gap : (~ramp_gap + 17'h00001);
  wire [15:0] ramp_next = (gap_mag <= {1'b0, rstep_a}) ? ramp_input_reference :
    (ramp_up ? working_speed_reference + rstep_a : working_speed_reference - rstep_a);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_current_reference <= 16'h0000;
      firing_limit_hold <= 1'b0;
      firing_angle_limit <= 8'h00;
      current_loop_enable <= 1'b0;
      speed_integrator_clear <= 1'b0;
      working_speed_reference <= 16'h0000;
      drive_wait <= 1'b0;
      logic_out <= 6'h00;
      tacho_reversal_inhibit <= 1'b0;
      aux_variable <= 16'h0000;
    end else begin
      field_current_reference <= field_ref;
      firing_limit_hold <= reversing;
      firing_angle_limit <= reversing ? `LIMIT_ANGLE_DEG : 8'h00;
      current_loop_enable <= (state_reg == ST_RUN);
      drive_wait <= reversing;
      logic_out <= logic_next;
      tacho_reversal_inhibit <= rev_en;
      speed_integrator_clear <= restart_load && ramp_enable;
      if (restart_load && ramp_enable) begin
        working_speed_reference <= measured_speed;
      end else if (!ramp_enable) begin
        working_speed_reference <= ramp_input_reference;
      end else if (tick) begin
        working_speed_reference <= ramp_next;
      end
      case (outsel_a[`OUT_AUX])
        2'h0: aux_variable <= speed_loop_current_demand;
        2'h1: aux_variable <= demand;
        2'h2: aux_variable <= working_speed_reference;
        default: aux_variable <= field_current_reference;
      endcase
    end
  end
endmodule // field_reversal_sequencer

// ---- tb/field_rev_chk.sv ----
// Port-level concurrent checks for the field reversal sequencer
`timescale 1ns/1ns
module field_rev_chk #(
  parameter integer CLKS_10MS = 100000, // Clocks per 10 ms cycle
  parameter integer CLKS_5MS = 50000, // Clocks per 5 ms cycle
  parameter integer CLKS_3MS3 = 33000 // Clocks per 3.3 ms cycle
) (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire hreadyout, // Slave ready
  input wire hresp, // Slave response
  input wire regulating, // Regulation state
  input wire ramp_enable, // Ramp on
  input wire firing_limit_hold, // Firing held at limit
  input wire [7:0] firing_angle_limit, // Limit angle
  input wire current_loop_enable, // Current loop on
  input wire speed_integrator_clear, // Integrator clear pulse
  input wire drive_wait, // Speed loop waiting
  input wire [5:0] logic_out, // Logic outputs
  input wire tacho_reversal_inhibit // Tacho protection off
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence off_s;
    !regulating [*2];
  endsequence
  sequence restart_s;
    $fell(firing_limit_hold);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  hold_angle_a: assert property (firing_limit_hold |-> firing_angle_limit == 8'ha5)
    else $error("limit angle wrong while holding");
  hold_loop_a: assert property (firing_limit_hold |-> !current_loop_enable)
    else $error("current loop on while holding");
  wait_hold_a: assert property (drive_wait == firing_limit_hold)
    else $error("drive wait differs from hold");
  rev_pair_a: assert property (firing_limit_hold |-> $countones(logic_out) == 2)
    else $error("indicators not both high while reversing");
  run_single_a: assert property (current_loop_enable |-> $countones(logic_out) == 1)
    else $error("settled field shows not one indicator");
  off_quiet_a: assert property (off_s |=> logic_out == 6'h00 && !current_loop_enable)
    else $error("outputs active outside regulation");
  clear_pulse_a: assert property (speed_integrator_clear |-> $past(ramp_enable) ##1 !speed_integrator_clear)
    else $error("integrator clear not a single ramp pulse");
  tacho_inhibit_a: assert property (firing_limit_hold |-> tacho_reversal_inhibit)
    else $error("tacho protection live during reversal");
  restart_loop_a: assert property (restart_s |-> current_loop_enable ^ (logic_out == 6'h00))
    else $error("hold ended without restart or stop");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule // field_rev_chk

bind field_reversal_sequencer field_rev_chk #(.CLKS_10MS(CLKS_10MS), .CLKS_5MS(CLKS_5MS),
  .CLKS_3MS3(CLKS_3MS3)) field_rev_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .regulating(regulating), .ramp_enable(ramp_enable),
  .firing_limit_hold(firing_limit_hold), .firing_angle_limit(firing_angle_limit),
  .current_loop_enable(current_loop_enable), .speed_integrator_clear(speed_integrator_clear),
  .drive_wait(drive_wait), .logic_out(logic_out), .tacho_reversal_inhibit(tacho_reversal_inhibit));

// ---- tb/field_exciter_model.sv ----
// Reversible field exciter model: measured field current slews toward the reference
`timescale 1ns/1ns
module field_exciter_model (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire [15:0] field_current_reference, // Reference from the sequencer
  input wire [15:0] lag_step, // Slew per clock, small for a slow field
  output reg [15:0] field_current_meas // Measured field current
);
  wire signed [16:0] err = $signed(field_current_reference) - $signed(field_current_meas);
  // A real field winding cannot jump, so with a small lag_step reversal takes many clocks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_current_meas <= 16'h0000;
    end else if (err > $signed({1'b0, lag_step})) begin
      field_current_meas <= field_current_meas + lag_step;
    end else if (err < -$signed({1'b0, lag_step})) begin
      field_current_meas <= field_current_meas - lag_step;
    end else begin
      field_current_meas <= field_current_reference;
    end
  end
endmodule // field_exciter_model

// ---- tb/tb.sv ----
// Self-checking bench for the field reversal sequencer
`timescale 1ns/1ns
`define chk(nm, e, g) begin comparisons = comparisons + 1; if ((e) !== (g)) begin \
  fails = fails + 1; $display("wrong value %s expected %h seen %h", nm, e, g); end end
`define wait_until(c) begin wn = 0; while ((c) !== 1'b1 && wn < 3000) begin \
  @(posedge hclk); wn = wn + 1; end if (wn >= 3000) begin fails = fails + 1; stop_test; end end
module tb;
  reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2;
  reg [15:0] speed_loop_current_demand = 16'h0100, alt_current_demand = 16'h0000;
  reg [15:0] measured_speed = 16'h0200, ramp_input_reference = 16'h0200, lag_step = 16'h0100;
  reg [15:0] d = 16'h0;
  reg ramp_enable = 1'b0, regulating = 1'b1, motor_stopped = 1'b0, clr_seen = 1'b0;
  reg loss_of_field_fault = 1'b0, av_sensor_fault = 1'b0;
  wire hreadyout, hresp, firing_limit_hold, current_loop_enable, speed_integrator_clear;
  wire drive_wait, tacho_reversal_inhibit;
  wire [31:0] hrdata;
  wire [15:0] field_current_meas, field_current_reference, working_speed_reference, aux_variable;
  wire [7:0] firing_angle_limit;
  wire [5:0] logic_out;
  integer fails = 0, comparisons = 0, wn = 0, n = 0, c = 0;
  always #50 hclk = ~hclk;
  field_reversal_sequencer #(.CLKS_10MS(20), .CLKS_5MS(10), .CLKS_3MS3(7))
    field_reversal_sequencer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .speed_loop_current_demand(speed_loop_current_demand),
    .alt_current_demand(alt_current_demand), .field_current_meas(field_current_meas),
    .measured_speed(measured_speed), .ramp_input_reference(ramp_input_reference),
    .ramp_enable(ramp_enable), .regulating(regulating), .motor_stopped(motor_stopped),
    .loss_of_field_fault(loss_of_field_fault), .av_sensor_fault(av_sensor_fault),
    .field_current_reference(field_current_reference), .firing_limit_hold(firing_limit_hold),
    .firing_angle_limit(firing_angle_limit), .current_loop_enable(current_loop_enable),
    .speed_integrator_clear(speed_integrator_clear),
    .working_speed_reference(working_speed_reference), .drive_wait(drive_wait),
    .logic_out(logic_out), .tacho_reversal_inhibit(tacho_reversal_inhibit),
    .aux_variable(aux_variable));
  field_exciter_model field_exciter_model_i (.hclk(hclk), .hresetn(hresetn),
    .field_current_reference(field_current_reference), .lag_step(lag_step),
    .field_current_meas(field_current_meas));
  // ----------------------------------------------------------------
  // Bus and timing helpers
  // ----------------------------------------------------------------
  task bus(input [7:0] a, input w, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      `wait_until(hreadyout)
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      `wait_until(hreadyout)
      rd = hrdata;
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      `chk("register", e, rd)
    end
  endtask
  // Only valid while the 10 ms period code is active
  task ticks(input integer k);
    repeat (k * 20) @(posedge hclk);
  endtask
  task stop_test;
    begin
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    begin
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0400);
      rd_chk(8'h08, 32'h0014);
      rd_chk(8'h0c, 32'h0800);
      rd_chk(8'h10, 32'h0064);
      rd_chk(8'h14, 32'h0010);
      rd_chk(8'h18, 32'h4000);
      rd_chk(8'h1c, 32'h0010);
      bus(8'h24, 1'b1, 32'h5a5a);
      rd_chk(8'h24, 32'h0);
      bus(8'h04, 1'b1, 32'h1234);
      rd_chk(8'h04, 32'h1234);
      bus(8'h04, 1'b1, 32'h0400);
    end
  endtask
  task t_off;
    begin
      speed_loop_current_demand <= 16'hf800;
      ticks(4);
      `chk("hold", 1'b0, firing_limit_hold)
      `chk("fref", 16'h4000, field_current_reference)
      `chk("ind", 6'h02, logic_out)
      `chk("tacho", 1'b0, tacho_reversal_inhibit)
    end
  endtask
  task t_below;
    begin
      bus(8'h08, 1'b1, 32'h3);
      speed_loop_current_demand <= 16'hfd00;
      bus(8'h00, 1'b1, 32'h1);
      ticks(3);
      `chk("hold", 1'b0, firing_limit_hold)
      `chk("fref", 16'h4000, field_current_reference)
      `chk("tacho", 1'b1, tacho_reversal_inhibit)
    end
  endtask
  task t_reverse;
    begin
      loss_of_field_fault <= 1'b1;
      av_sensor_fault <= 1'b1;
      ramp_enable <= 1'b1;
      ramp_input_reference <= 16'h1000;
      speed_loop_current_demand <= 16'hf800;
      `wait_until(firing_limit_hold)
      `chk("angle", 8'ha5, firing_angle_limit)
      `chk("loop", 1'b0, current_loop_enable)
      `chk("wait", 1'b1, drive_wait)
      `chk("ind", 6'h03, logic_out)
      `chk("fref", 16'hc000, field_current_reference)
      ticks(8);
      loss_of_field_fault <= 1'b0;
      ticks(3);
      `chk("hold", 1'b1, firing_limit_hold)
      av_sensor_fault <= 1'b0;
      n = 0;
      clr_seen = 1'b0;
      while (current_loop_enable !== 1'b1 && n < 300) begin
        @(posedge hclk);
        n = n + 1;
        clr_seen = clr_seen | (speed_integrator_clear === 1'b1);
      end
      `chk("restart delay", 1'b1, n >= 60 && n <= 84)
      `chk("wsr", 16'h0200, working_speed_reference)
      `chk("ind", 6'h01, logic_out)
      @(posedge hclk);
      clr_seen = clr_seen | (speed_integrator_clear === 1'b1);
      `chk("clear", 1'b1, clr_seen)
      ticks(4);
      d = working_speed_reference - 16'h0200;
      `chk("ramp", 1'b1, d[3:0] == 4'h0 && d >= 16'h30 && d <= 16'h50)
    end
  endtask
  task t_double;
    begin
      lag_step <= 16'h0020;
      speed_loop_current_demand <= 16'h0800;
      `wait_until(firing_limit_hold)
      `chk("fref", 16'h4000, field_current_reference)
      ticks(2);
      speed_loop_current_demand <= 16'hf800;
      ticks(2);
      `chk("fref", 16'hc000, field_current_reference)
      `chk("hold", 1'b1, firing_limit_hold)
      lag_step <= 16'h0100;
      `wait_until(current_loop_enable)
      `chk("ind", 6'h01, logic_out)
    end
  endtask
  task t_outsel;
    begin
      bus(8'h14, 1'b1, 32'h054);
      ticks(2);
      `chk("ind", 6'h10, logic_out)
      `chk("aux", 16'hf800, aux_variable)
      bus(8'h14, 1'b1, 32'h354);
      ticks(2);
      `chk("aux", 16'hc000, aux_variable)
      bus(8'h14, 1'b1, 32'h010);
    end
  endtask
  task t_period;
    begin
      ramp_input_reference <= 16'h7000;
      for (c = 0; c < 3; c = c + 1) begin
        bus(8'h00, 1'b1, {29'h0, c[1:0], 1'b1});
        ticks(2);
        d = working_speed_reference;
        `wait_until(working_speed_reference !== d)
        d = working_speed_reference;
        `wait_until(working_speed_reference !== d)
        `chk("period", (c == 0) ? 20 : (c == 1) ? 10 : 7, wn)
      end
      bus(8'h00, 1'b1, 32'h1);
    end
  endtask
  task t_saving;
    begin
      bus(8'h10, 1'b1, 32'h4);
      ticks(1);
      motor_stopped <= 1'b1;
      regulating <= 1'b0;
      repeat (3) @(posedge hclk);
      `chk("ind", 6'h00, logic_out)
      ticks(2);
      `chk("fref", 16'hc000, field_current_reference)
      ticks(4);
      `chk("fref", 16'hf800, field_current_reference)
      regulating <= 1'b1;
      ticks(2);
      `chk("fref", 16'hc000, field_current_reference)
    end
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_off;
    t_below;
    t_reverse;
    t_double;
    t_outsel;
    t_period;
    t_saving;
    stop_test;
  end
endmodule // tb
